//--- inc/buck_consts.svh
`ifndef BUCK_CONSTS_SVH
`define BUCK_CONSTS_SVH

// clock and switching timing
`define HCLK_HZ          50000000
`define SW_FREQ_HZ       300000
`define SW_CNT_W         8
`define BOOST_DIV        3

// mode control
`define MODE_SAMPLES     8
`define SAMPLE_CNT_W     4

// soft-start length, in switching periods
`define SS_W             16

// register byte offsets
`define REG_CTRL_OFS     8'h00
`define REG_SSLEN_OFS    8'h04
`define REG_STATUS_OFS   8'h08

// control register fields
`define CTRL_W           3
`define CTRL_HYST1_BIT   0
`define CTRL_HYST2_BIT   1
`define CTRL_BOOST_BIT   2
`define CTRL_RESET       3'h7

`define SSLEN_RESET      16'h0100

// status register fields
`define ST_HYST1_BIT     0
`define ST_HYST2_BIT     1
`define ST_STANDBY_BIT   2
`define ST_MAIN5_BIT     3
`define ST_MAIN3_BIT     4
`define ST_SS5_BIT       5
`define ST_SS3_BIT       6
`define ST_BOOST_BIT     7

`endif

//--- inc/buck_pkg.sv
`include "buck_consts.svh"

package buck_pkg;

  // gray path: off -> pwm -> hysteretic
  typedef enum logic [1:0] {
    MODE_OFF  = 2'h0,
    MODE_PWM  = 2'h1,
    MODE_HYST = 2'h3
  } mode_t;

  typedef struct packed {
    mode_t                    mode;
    logic [`SAMPLE_CNT_W-1:0] pos_cnt;
    logic [`SAMPLE_CNT_W-1:0] neg_cnt;
    logic                     pwm_on;
    logic                     hy_hs;
    logic                     hy_ls;
    logic                     to_pwm;
    logic                     hs_gate;
    logic                     ls_gate;
  } chan_state_t;

  typedef struct packed {
    logic [`SW_CNT_W-1:0]     sw_cnt;
    logic [1:0]               tick;
    logic [1:0]               div3;
    logic                     clk3;
    logic                     boost_run;
    logic                     boost_gate;
    logic [`CTRL_W-1:0]       ctrl;
    logic [`SS_W-1:0]         ss_len;
    logic [1:0][`SS_W-1:0]    ss_cnt;
    logic [1:0]               ss_act;
    logic [1:0]               rail_en;
    logic                     aon;
    logic                     wr_pend;
    logic [7:0]               wr_addr;
    logic [31:0]              hrdata;
    logic                     hreadyout;
  } top_state_t;

endpackage : buck_pkg

//--- logic/buck_channel.sv
`timescale 1ns/10ps
`default_nettype none
`include "buck_consts.svh"

module buck_channel #(
  parameter int unsigned SAMPLES = `MODE_SAMPLES
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // control
  input  wire logic tick,
  input  wire logic enable,
  input  wire logic hyst_allow,
  // modulator and comparators
  input  wire logic pwm_hi_req,
  input  wire logic hyst_at_lower,
  input  wire logic hyst_at_upper,
  input  wire logic hyst_below_level,
  input  wire logic phase_cmp,
  // gate-to-source monitors
  input  wire logic hs_vgs_low,
  input  wire logic ls_vgs_low,
  // gate drive and mode
  output logic      hs_gate,
  output logic      ls_gate,
  output logic      hyst_mode
);

  localparam logic [`SAMPLE_CNT_W-1:0] LAST = `SAMPLE_CNT_W'(SAMPLES - 1);

  buck_pkg::chan_state_t q, d;
  logic sample;
  logic hs_req;
  logic ls_req;

  always_comb begin
    d = q;
    // sample at the end of low-side conduction, just before high-side on
    sample = tick & q.ls_gate;
    case (q.mode)
      buck_pkg::MODE_OFF: begin
        if (enable) begin
          d.mode = buck_pkg::MODE_PWM;
        end
      end
      buck_pkg::MODE_PWM: begin
        if (tick) begin
          d.pwm_on = 1'b1;
        end else if (!pwm_hi_req) begin
          d.pwm_on = 1'b0;
        end
        if (sample) begin
          d.pos_cnt = phase_cmp ? q.pos_cnt + 1'b1 : '0;
        end
        if (sample && phase_cmp && q.pos_cnt == LAST && hyst_allow) begin
          d.mode    = buck_pkg::MODE_HYST;
          d.pos_cnt = '0;
          d.neg_cnt = '0;
          d.pwm_on  = 1'b0;
        end
      end
      buck_pkg::MODE_HYST: begin
        if (hyst_below_level) begin
          d.to_pwm = 1'b1;
        end
        if (tick && hyst_at_lower) begin
          d.hy_hs = 1'b1;
          d.hy_ls = 1'b0;
        end else if (q.hy_hs && hyst_at_upper) begin
          d.hy_hs = 1'b0;
          d.hy_ls = 1'b1;
        end else if (tick) begin
          d.hy_ls = 1'b0;
        end
        if (sample) begin
          d.neg_cnt = !phase_cmp ? q.neg_cnt + 1'b1 : '0;
        end
        if (tick && (q.to_pwm || !hyst_allow ||
            (sample && !phase_cmp && q.neg_cnt == LAST))) begin
          d.mode    = buck_pkg::MODE_PWM;
          d.pos_cnt = '0;
          d.neg_cnt = '0;
          d.to_pwm  = 1'b0;
          d.hy_hs   = 1'b0;
          d.hy_ls   = 1'b0;
          d.pwm_on  = 1'b1;
        end
      end
      default: begin
        d.mode = buck_pkg::MODE_OFF;
      end
    endcase
    if (!enable) begin
      d = '0;
    end
    hs_req = (d.mode == buck_pkg::MODE_PWM  &&  d.pwm_on) ||
             (d.mode == buck_pkg::MODE_HYST &&  d.hy_hs);
    ls_req = (d.mode == buck_pkg::MODE_PWM  && !d.pwm_on) ||
             (d.mode == buck_pkg::MODE_HYST &&  d.hy_ls);
    // adaptive dead time: the opposite gate must be off and discharged
    d.hs_gate = hs_req & (q.hs_gate | (!q.ls_gate & ls_vgs_low));
    d.ls_gate = ls_req & !hs_req &
                (q.ls_gate | (!q.hs_gate & hs_vgs_low));
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign hs_gate   = q.hs_gate;
  assign ls_gate   = q.ls_gate;
  assign hyst_mode = (q.mode == buck_pkg::MODE_HYST);

endmodule : buck_channel

`default_nettype wire

//--- logic/buck_mode_and_rail_enable_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "buck_consts.svh"

module buck_mode_and_rail_enable_ctrl #(
  parameter int unsigned SW_PERIOD = `HCLK_HZ / `SW_FREQ_HZ,
  parameter int unsigned SAMPLES   = `MODE_SAMPLES
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // shutdown controls
  input  wire logic              master_shutdown_n,
  input  wire logic              main5_enable_softstart,
  input  wire logic              main3_enable_softstart,
  // buck modulators and comparators, index 0 is the 5V main
  input  wire logic [1:0]        pwm_hi_req,
  input  wire logic [1:0]        hyst_at_lower,
  input  wire logic [1:0]        hyst_at_upper,
  input  wire logic [1:0]        hyst_below_level,
  input  wire logic [1:0]        phase_cmp,
  input  wire logic [1:0]        hs_vgs_low,
  input  wire logic [1:0]        ls_vgs_low,
  // buck gate drive
  output logic      [1:0]        hs_gate,
  output logic      [1:0]        ls_gate,
  // boost
  input  wire logic              boost_feedback_sense,
  input  wire logic              boost_ramp_above_err,
  output logic                   boost_gate,
  output logic                   boost_clk3,
  // rail status
  output logic                   always_on_en,
  output logic      [1:0]        main_rail_en,
  output logic      [1:0]        main_ss_active
);

  localparam logic [`SW_CNT_W-1:0] SW_LAST =
    `SW_CNT_W'(SW_PERIOD - 1);
  localparam logic [`SW_CNT_W-1:0] SW_HALF =
    `SW_CNT_W'(SW_PERIOD / 2);
  localparam logic [1:0] DIV_LAST = 2'(`BOOST_DIV - 1);

  buck_pkg::top_state_t q, d;
  logic [1:0]  hyst_mode;
  logic [1:0]  ch_hs;
  logic [1:0]  ch_ls;
  logic [1:0]  en_req;
  logic [1:0]  hyst_allow;
  logic        addr_phase;
  logic [31:0] status;

  function automatic logic [31:0] reg_read(
    input logic [7:0]        addr,
    input logic [`CTRL_W-1:0] ctrl,
    input logic [`SS_W-1:0]  ss_len,
    input logic [31:0]       stat
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    if (addr == `REG_CTRL_OFS) begin
      r[`CTRL_W-1:0] = ctrl;
    end else if (addr == `REG_SSLEN_OFS) begin
      r[`SS_W-1:0] = ss_len;
    end else if (addr == `REG_STATUS_OFS) begin
      r = stat;
    end
    return r;
  endfunction : reg_read

  assign en_req     = {main3_enable_softstart, main5_enable_softstart};
  assign hyst_allow = {q.ctrl[`CTRL_HYST2_BIT], q.ctrl[`CTRL_HYST1_BIT]};
  assign addr_phase = hsel & htrans[1] & hready;

  always_comb begin
    d = q;
    status = 32'h0000_0000;

    // switching clock; second channel ticks half a period later
    d.sw_cnt = (q.sw_cnt == SW_LAST) ? '0 : q.sw_cnt + 1'b1;
    d.tick[0] = (d.sw_cnt == '0);
    d.tick[1] = (d.sw_cnt == SW_HALF);

    // one switching period high out of every three
    if (d.tick[0]) begin
      d.div3 = (q.div3 == DIV_LAST) ? 2'h0 : q.div3 + 2'h1;
      d.clk3 = (d.div3 == 2'h0);
    end

    // rail decode; a low master shutdown overrides everything
    d.aon     = master_shutdown_n;
    d.rail_en = master_shutdown_n ? en_req : 2'b00;

    // soft-start runs its full length, regulation or not
    for (int i = 0; i < 2; i++) begin
      if (!d.rail_en[i]) begin
        d.ss_cnt[i] = '0;
        d.ss_act[i] = 1'b0;
      end else if (!q.rail_en[i]) begin
        d.ss_cnt[i] = '0;
        d.ss_act[i] = 1'b1;
      end else if (q.ss_act[i] && q.tick[0]) begin
        d.ss_cnt[i] = q.ss_cnt[i] + 1'b1;
        if (d.ss_cnt[i] >= q.ss_len) begin
          d.ss_act[i] = 1'b0;
        end
      end
    end

    // boost runs with the 5V main unless its sense is strapped high
    d.boost_run = d.rail_en[0] & ~boost_feedback_sense &
                  q.ctrl[`CTRL_BOOST_BIT];
    if (!q.boost_run) begin
      d.boost_gate = 1'b0;
    end else if (q.clk3 && !d.clk3) begin
      d.boost_gate = 1'b0;
    end else if (q.clk3 && boost_ramp_above_err) begin
      // setting only inside the pulse keeps duty under one third
      d.boost_gate = 1'b1;
    end

    status[`ST_HYST1_BIT]   = hyst_mode[0];
    status[`ST_HYST2_BIT]   = hyst_mode[1];
    status[`ST_STANDBY_BIT] = q.aon & ~q.rail_en[0] & ~q.rail_en[1];
    status[`ST_MAIN5_BIT]   = q.rail_en[0];
    status[`ST_MAIN3_BIT]   = q.rail_en[1];
    status[`ST_SS5_BIT]     = q.ss_act[0];
    status[`ST_SS3_BIT]     = q.ss_act[1];
    status[`ST_BOOST_BIT]   = q.boost_run;

    // write data phase; unmapped writes are dropped
    if (q.wr_pend) begin
      if (q.wr_addr == `REG_CTRL_OFS) begin
        d.ctrl = hwdata[`CTRL_W-1:0];
      end else if (q.wr_addr == `REG_SSLEN_OFS) begin
        d.ss_len = hwdata[`SS_W-1:0];
      end
    end

    // address phase; read data uses post-write values so a read
    // right after a write sees the new contents
    d.wr_pend   = addr_phase & hwrite;
    d.wr_addr   = haddr[7:0];
    d.hreadyout = 1'b1;
    if (addr_phase && !hwrite) begin
      d.hrdata = reg_read(haddr[7:0], d.ctrl, d.ss_len, status);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q           <= '0;
      q.ctrl      <= `CTRL_RESET;
      q.ss_len    <= `SSLEN_RESET;
      q.hreadyout <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // one controller per main rail, each on its own phase tick
  for (genvar g = 0; g < 2; g++) begin : g_chan
    buck_channel #(
      .SAMPLES (SAMPLES)
    ) u_chan (
      .hclk             (hclk),
      .hresetn          (hresetn),
      .tick             (q.tick[g]),
      .enable           (q.rail_en[g]),
      .hyst_allow       (hyst_allow[g]),
      .pwm_hi_req       (pwm_hi_req[g]),
      .hyst_at_lower    (hyst_at_lower[g]),
      .hyst_at_upper    (hyst_at_upper[g]),
      .hyst_below_level (hyst_below_level[g]),
      .phase_cmp        (phase_cmp[g]),
      .hs_vgs_low       (hs_vgs_low[g]),
      .ls_vgs_low       (ls_vgs_low[g]),
      .hs_gate          (ch_hs[g]),
      .ls_gate          (ch_ls[g]),
      .hyst_mode        (hyst_mode[g])
    );
  end

  assign hs_gate        = ch_hs;
  assign ls_gate        = ch_ls;
  assign hrdata         = q.hrdata;
  assign hreadyout      = q.hreadyout;
  assign hresp          = 1'b0;
  assign boost_gate     = q.boost_gate;
  assign boost_clk3     = q.clk3;
  assign always_on_en   = q.aon;
  assign main_rail_en   = q.rail_en;
  assign main_ss_active = q.ss_act;

endmodule : buck_mode_and_rail_enable_ctrl

`default_nettype wire

//--- verif/buck_ctrl_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module buck_ctrl_checker #(
  parameter int unsigned SW_PERIOD = 166
) (
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // shutdown controls
  input wire logic       master_shutdown_n,
  input wire logic       main5_enable_softstart,
  input wire logic       main3_enable_softstart,
  // buck gates and monitors
  input wire logic [1:0] hs_vgs_low,
  input wire logic [1:0] ls_vgs_low,
  input wire logic [1:0] hs_gate,
  input wire logic [1:0] ls_gate,
  // boost
  input wire logic       boost_feedback_sense,
  input wire logic       boost_ramp_above_err,
  input wire logic       boost_gate,
  input wire logic       boost_clk3,
  // rails
  input wire logic       always_on_en,
  input wire logic [1:0] main_rail_en,
  input wire logic [1:0] main_ss_active
);
  logic [15:0] hi_cnt_q;
  logic [15:0] hi_cnt_d;
  always_comb hi_cnt_d = boost_clk3 ? hi_cnt_q + 16'h0001 : 16'h0000;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hi_cnt_q <= 16'h0000;
    else hi_cnt_q <= hi_cnt_d;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ls_wait_a: assert property ($rose(ls_gate[0]) |->
    $past(hs_vgs_low[0]) && !$past(hs_gate[0])) else $error("ls early");
  hs_wait_a: assert property ($rose(hs_gate[1]) |->
    $past(ls_vgs_low[1]) && !$past(ls_gate[1])) else $error("hs early");
  all_off_a: assert property (!master_shutdown_n [*4] |->
    !always_on_en && main_rail_en == 2'h0 && hs_gate == 2'h0
    && ls_gate == 2'h0 && !boost_gate) else $error("not all off");
  rail_follow_a: assert property ($past(hresetn) && master_shutdown_n
    |=> always_on_en && main_rail_en == $past({main3_enable_softstart,
    main5_enable_softstart})) else $error("rail mismatch");
  ss_start_a: assert property ($rose(main_rail_en[0]) |->
    main_ss_active[0]) else $error("no soft start");
  boost_width_a: assert property ($fell(boost_clk3) |->
    hi_cnt_q == SW_PERIOD) else $error("clk3 width");
  boost_set_a: assert property ($rose(boost_gate) |->
    $past(boost_clk3) && $past(boost_ramp_above_err)) else $error("set");
  boost_clear_a: assert property ($fell(boost_clk3) |->
    !boost_gate) else $error("gate not cleared");
  boost_off_a: assert property (boost_feedback_sense [*3] |->
    !boost_gate) else $error("boost not disabled");
  cover property ($rose(boost_gate));
  cover property ($rose(ls_gate[0]));
  cover property ($fell(main_ss_active[0]));
endmodule : buck_ctrl_checker
bind buck_mode_and_rail_enable_ctrl buck_ctrl_checker #(
  .SW_PERIOD(SW_PERIOD)) chk_u (.hclk(hclk), .hresetn(hresetn),
  .master_shutdown_n(master_shutdown_n), .hs_gate(hs_gate),
  .main5_enable_softstart(main5_enable_softstart), .ls_gate(ls_gate),
  .main3_enable_softstart(main3_enable_softstart),
  .hs_vgs_low(hs_vgs_low), .ls_vgs_low(ls_vgs_low),
  .boost_feedback_sense(boost_feedback_sense), .boost_gate(boost_gate),
  .boost_ramp_above_err(boost_ramp_above_err), .boost_clk3(boost_clk3),
  .always_on_en(always_on_en), .main_rail_en(main_rail_en),
  .main_ss_active(main_ss_active));
`default_nettype wire

//--- verif/gate_monitor_model.sv
`timescale 1ns/10ps
`default_nettype none
module gate_monitor_model (
  // clock, reset, driver speed
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        slow,
  // gate drives
  input wire logic  [1:0] hs_gate,
  input wire logic  [1:0] ls_gate,
  // discharge monitors
  output logic      [1:0] hs_vgs_low,
  output logic      [1:0] ls_vgs_low
);
  logic [2:0] off_q [4];
  logic [3:0] g;
  logic [3:0] v;
  assign g = {ls_gate, hs_gate};
  always @(posedge hclk or negedge hresetn) begin
    for (int i = 0; i < 4; i++) begin
      if (!hresetn) off_q[i] <= 3'h7;
      else if (g[i]) off_q[i] <= 3'h0;
      else if (off_q[i] != 3'h7) off_q[i] <= off_q[i] + 3'h1;
    end
  end
  // a charged gate reads high at once; slow drivers discharge in 4
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      v[i] = !g[i] && off_q[i] >= (slow ? 3'h4 : 3'h1);
    end
  end
  assign {ls_vgs_low, hs_vgs_low} = v;
endmodule : gate_monitor_model
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "buck_consts.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  err_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench;
  localparam int SWP = 12;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, mshut_n = 0;
  logic m5 = 0, m3 = 0, sense = 0, ramp = 0, slow = 0, seen;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = '0, pwm = '0, lo = '0, up = '0, below = '0;
  logic [1:0] ph = '0, hs, ls, hsv, lsv, rail, ss;
  logic hreadyout, hresp, bgate, clk3, aon;
  int err_count = 0, checks_done = 0, cyc = 0, n;
  always #10 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    pwm <= {2{(cyc % 5) < 2}};
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end
  buck_mode_and_rail_enable_ctrl #(.SW_PERIOD(SWP), .SAMPLES(8)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .master_shutdown_n(mshut_n),
    .main5_enable_softstart(m5), .main3_enable_softstart(m3),
    .pwm_hi_req(pwm), .hyst_at_lower(lo), .hyst_at_upper(up),
    .hyst_below_level(below), .phase_cmp(ph), .hs_vgs_low(hsv),
    .ls_vgs_low(lsv), .hs_gate(hs), .ls_gate(ls),
    .boost_feedback_sense(sense), .boost_ramp_above_err(ramp),
    .boost_gate(bgate), .boost_clk3(clk3), .always_on_en(aon),
    .main_rail_en(rail), .main_ss_active(ss));
  gate_monitor_model mon_u (.hclk(hclk), .hresetn(hresetn), .slow(slow),
    .hs_gate(hs), .ls_gate(ls), .hs_vgs_low(hsv), .ls_vgs_low(lsv));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic t_regs();
    bus(0, `REG_CTRL_OFS, 0); `CHK("ctrl", 32'h7, rd)
    bus(0, `REG_SSLEN_OFS, 0); `CHK("sslen", 32'h100, rd)
    bus(1, `REG_SSLEN_OFS, 2);
    bus(0, `REG_SSLEN_OFS, 0); `CHK("sslen", 32'h2, rd)
    bus(0, 8'h10, 0); `CHK("unmapped", 32'h0, rd)
    $display("registers done");
  endtask : t_regs
  task automatic t_rails();
    for (int i = 0; i < 8; i++) begin
      {mshut_n, m3, m5} <= i[2:0];
      repeat (3) @(posedge hclk);
      `CHK("aon", i[2], aon)
      `CHK("rail", i[2] ? i[1:0] : 2'h0, rail)
      bus(0, `REG_STATUS_OFS, 0);
      `CHK("standby", i[2:0] == 3'h4, rd[`ST_STANDBY_BIT])
    end
    {mshut_n, m3, m5} <= 3'h4;
    repeat (3) @(posedge hclk);
    $display("rails done");
  endtask : t_rails
  task automatic t_soft();
    m5 <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK("ss5", 1'b1, ss[0])
    n = 0;
    while (ss[0] === 1'b1 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    `CHK("sslen", 1'b1, n > SWP / 2 && n <= 3 * SWP)
    bus(0, `REG_STATUS_OFS, 0);
    `CHK("boost run", 1'b1, rd[`ST_BOOST_BIT])
    $display("soft start done");
  endtask : t_soft
  task automatic t_boost();
    ramp <= 1'b1;
    n = 0;
    // start from a low phase so a whole pulse is measured
    while (clk3 !== 1'b0 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    n = 0;
    while (clk3 !== 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    n = 0;
    seen = 0;
    while (clk3 === 1'b1 && n < 200) begin
      @(posedge hclk);
      n++;
      seen |= bgate;
    end
    `CHK("clk3 high", SWP, n)
    `CHK("gate set", 1'b1, seen)
    n = 0;
    while (clk3 === 1'b0 && n < 200) begin
      @(posedge hclk);
      n++;
    end
    `CHK("clk3 low", 2 * SWP, n)
    sense <= 1'b1;
    repeat (4) @(posedge hclk);
    seen = 0;
    repeat (4 * SWP) begin
      @(posedge hclk);
      seen |= bgate;
    end
    `CHK("strapped", 1'b0, seen)
    {sense, ramp} <= 2'h0;
    $display("boost done");
  endtask : t_boost
  task automatic t_mode();
    slow <= 1'b1;
    ph <= 2'h3;
    n = 0;
    do begin
      bus(0, `REG_STATUS_OFS, 0);
      n++;
    end while (rd[`ST_HYST1_BIT] !== 1'b1 && n < 200);
    `CHK("to hyst", 1'b1, rd[`ST_HYST1_BIT])
    @(posedge hclk);
    `CHK("entry off", 2'h0, {hs[0], ls[0]})
    seen = 0;
    repeat (2 * SWP) begin
      @(posedge hclk);
      seen |= hs[0] | ls[0];
    end
    `CHK("idle off", 1'b0, seen)
    lo <= 2'h1;
    n = 0;
    while (hs[0] !== 1'b1 && n < 3 * SWP) begin
      @(posedge hclk);
      n++;
    end
    `CHK("pulse on", 1'b1, hs[0])
    {lo, up} <= 4'h1;
    n = 0;
    while (hs[0] === 1'b1 && n < 3 * SWP) begin
      @(posedge hclk);
      n++;
    end
    `CHK("pulse end", 1'b0, hs[0])
    up <= 2'h0;
    below <= 2'h1;
    repeat (SWP + 4) @(posedge hclk);
    bus(0, `REG_STATUS_OFS, 0);
    `CHK("to pwm", 1'b0, rd[`ST_HYST1_BIT])
    below <= 2'h0;
    n = 0;
    do begin
      bus(0, `REG_STATUS_OFS, 0);
      n++;
    end while (rd[`ST_HYST1_BIT] !== 1'b1 && n < 200);
    `CHK("re-enter", 1'b1, rd[`ST_HYST1_BIT])
    // pulses keep the low side conducting at each tick for sampling
    ph <= 2'h0;
    {lo, up} <= 4'h5;
    n = 0;
    do begin
      bus(0, `REG_STATUS_OFS, 0);
      n++;
    end while (rd[`ST_HYST1_BIT] !== 1'b0 && n < 200);
    `CHK("neg to pwm", 1'b0, rd[`ST_HYST1_BIT])
    `CHK("neg count", 1'b1, n >= 44)
    {lo, up} <= 4'h0;
    $display("mode done");
  endtask : t_mode
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_rails();
    t_soft();
    t_boost();
    t_mode();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
